/* rtl/ihd_pkg.sv */
// Package for the interrupt and halt dispatch unit: constants and carriers.
package ihd_pkg;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned IPL_W        = 5;
    localparam int unsigned NUM_GREGS    = 16;
    localparam int unsigned GREG_IDX_W   = 4;
    localparam int unsigned NUM_IRQ      = 4;
    localparam int unsigned BC_BLK_W     = 8;
    localparam int unsigned PC_PAR_W     = 8;
    localparam int unsigned PC_PAR_N     = 16;
    localparam int unsigned PC_PAR_IDX_W = 4;
    localparam int unsigned HCODE_W      = 8;

    localparam logic [IPL_W-1:0]      IPL_HALT        = 5'h1f;
    localparam logic [IPL_W-1:0]      IPL_RESET       = 5'h1f;
    localparam logic [HCODE_W-1:0]    HCODE_EXT_HALT  = 8'h02;
    localparam logic [GREG_IDX_W-1:0] GREG_PC_IDX     = 4'hf;
    localparam logic [GREG_IDX_W-1:0] GREG_SP_IDX     = 4'he;
    localparam int unsigned           PSL_IPL_LSB     = 16;
    localparam logic [DATA_W-1:0]     FW_ENTRY_DEF    = 32'h2004_0000;
    localparam logic [DATA_W-1:0]     SCB_BASE_DEF    = 32'h0000_0000;
    localparam logic [DATA_W-1:0]     PSL_RESET       = 32'h041f_0000;
    localparam logic [DATA_W-1:0]     GREG_RESET      = 32'h0000_0000;
    localparam logic [DATA_W-1:0]     VEC_STRIDE      = 32'h0000_0004;

    // Saved state captured on a halt.
    typedef struct packed {
        logic [DATA_W-1:0]  pc;
        logic [DATA_W-1:0]  processor_status_longword;
        logic               memory_mapping_enable;
        logic [HCODE_W-1:0] code;
    } ihd_halt_save_s;

    // Maskable interrupt request: level and vector offset into the control block.
    typedef struct packed {
        logic              valid;
        logic [IPL_W-1:0]  level;
        logic [DATA_W-1:0] offset;
    } ihd_irq_req_s;

    // General register write port from the instruction flow.
    typedef struct packed {
        logic                  we;
        logic [GREG_IDX_W-1:0] idx;
        logic [DATA_W-1:0]     data;
    } ihd_greg_wr_s;

    // Internal processor register access for the cache groups.
    typedef struct packed {
        logic                    bc_dealloc;
        logic [BC_BLK_W-1:0]     bc_blk;
        logic                    par_we;
        logic [PC_PAR_IDX_W-1:0] par_idx;
        logic [PC_PAR_W-1:0]     par_data;
    } ihd_ipr_wr_s;

    typedef enum logic [1:0] {
        IHD_RUN    = 2'b00,
        IHD_HALT   = 2'b01,
        IHD_VFETCH = 2'b10
    } ihd_state_e;
endpackage : ihd_pkg

/* rtl/ihd_sync2.sv */
// Two-flop synchroniser for one asynchronous line.
`timescale 1ns/100ps
`default_nettype none
module ihd_sync2
    import ihd_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output var  logic q_o
);
    logic meta_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            q_o      <= 1'b0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule : ihd_sync2
`default_nettype wire

/* rtl/ihd_dispatch.sv */
// Interrupt and halt dispatch unit of the processor.
// Overview of operation
// - A halt saves program counter, status longword, mapping enable bit 0 and halt code.
// - A halt forces the interrupt priority level to 1F.
// - After saving and raising the level the halt jumps to the firmware entry.
// - A halt request is taken whatever the current priority level is.
// - A maskable interrupt saves program counter and status longword first.
// - A maskable interrupt sets the level to that of the interrupt taken.
// - A maskable interrupt reads its vector from the control block table and branches.
// - General register 15 is the program counter holding the next fetch address.
// - General register 14 is the stack top pointer.
// - A write to a deallocate register frees the matching backup cache block.
// - A read-write register group reaches the primary cache data parity bits.
// - The external halt line is nonmaskable at level 1F.
// - An external halt records halt code 2.
// - Sixteen general registers, 0 through 15, are provided.
`timescale 1ns/100ps
`default_nettype none
module ihd_dispatch
    import ihd_pkg::*;
#(
    parameter logic [DATA_W-1:0] FW_ENTRY = FW_ENTRY_DEF,
    parameter logic [DATA_W-1:0] SCB_BASE = SCB_BASE_DEF
)(
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    halt_req_i,
    input  wire ihd_irq_req_s            irq_req_i,
    input  wire ihd_greg_wr_s            greg_wr_i,
    input  wire logic [DATA_W-1:0]       psl_wr_data_i,
    input  wire logic                    psl_we_i,
    input  wire logic                    memory_mapping_enable_i,
    input  wire ihd_ipr_wr_s             ipr_wr_i,
    input  wire logic [PC_PAR_IDX_W-1:0] par_rd_idx_i,
    input  wire logic                    vec_valid_i,
    input  wire logic [DATA_W-1:0]       vec_data_i,
    output var  logic                    vec_rd_o,
    output var  logic [DATA_W-1:0]       vec_addr_o,
    output var  ihd_halt_save_s          halt_save_o,
    output var  logic                    halt_taken_o,
    output var  logic                    irq_taken_o,
    output var  logic [IPL_W-1:0]        ipl_o,
    output var  logic [DATA_W-1:0]       pc_o,
    output var  logic [DATA_W-1:0]       sp_o,
    output var  logic [DATA_W-1:0]       saved_pc_o,
    output var  logic [DATA_W-1:0]       saved_psl_o,
    output var  logic                    bc_dealloc_o,
    output var  logic [BC_BLK_W-1:0]     bc_blk_o,
    output var  logic [PC_PAR_W-1:0]     par_rd_data_o
);
    // ------------------------------------------------------------------
    // Input synchronisation and state
    // ------------------------------------------------------------------
    logic                 halt_sync;
    ihd_state_e           state_reg;
    ihd_state_e           state_next;
    logic [DATA_W-1:0]    greg_reg [NUM_GREGS];
    logic [DATA_W-1:0]    psl_reg;
    logic [PC_PAR_W-1:0]  par_reg [PC_PAR_N];
    logic [IPL_W-1:0]     cur_ipl;
    logic                 halt_go;
    logic                 irq_go;

    // The halt line is asynchronous to the core, so it is synchronised first.
    ihd_sync2 u_halt_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (halt_req_i),
        .q_o   (halt_sync)
    );

    assign cur_ipl = psl_reg[PSL_IPL_LSB +: IPL_W];
    assign halt_go = halt_sync && (state_reg == IHD_RUN);
    assign irq_go  = !halt_go && (state_reg == IHD_RUN) && irq_req_i.valid
                     && (irq_req_i.level > cur_ipl);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            IHD_RUN: begin
                if (halt_go) begin
                    state_next = IHD_HALT;
                end else if (irq_go) begin
                    state_next = IHD_VFETCH;
                end
            end
            IHD_HALT: begin
                // Firmware releases the halt by rewriting the status longword once the halt line has dropped.
                if (psl_we_i && !halt_sync) begin
                    state_next = IHD_RUN;
                end
            end
            IHD_VFETCH: begin
                if (vec_valid_i) begin
                    state_next = IHD_RUN;
                end
            end
            default: begin
                state_next = IHD_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= IHD_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // General registers, status longword and saved state
    // ------------------------------------------------------------------
    // Sixteen registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_GREGS; i++) begin
                greg_reg[i] <= GREG_RESET;
            end
        end else if (halt_go) begin
            greg_reg[GREG_PC_IDX] <= FW_ENTRY;
        end else if (state_reg == IHD_VFETCH && vec_valid_i) begin
            greg_reg[GREG_PC_IDX] <= vec_data_i;
        end else if (greg_wr_i.we) begin
            greg_reg[greg_wr_i.idx] <= greg_wr_i.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            psl_reg <= PSL_RESET;
        end else if (halt_go) begin
            psl_reg[PSL_IPL_LSB +: IPL_W] <= IPL_HALT;
        end else if (irq_go) begin
            psl_reg[PSL_IPL_LSB +: IPL_W] <= irq_req_i.level;
        end else if (psl_we_i) begin
            psl_reg <= psl_wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            halt_save_o <= '0;
        end else if (halt_go) begin
            halt_save_o.pc    <= greg_reg[GREG_PC_IDX];
            halt_save_o.processor_status_longword   <= psl_reg;
            halt_save_o.memory_mapping_enable <= memory_mapping_enable_i;
            halt_save_o.code  <= HCODE_EXT_HALT;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            saved_pc_o  <= GREG_RESET;
            saved_psl_o <= GREG_RESET;
        end else if (irq_go) begin
            saved_pc_o  <= greg_reg[GREG_PC_IDX];
            saved_psl_o <= psl_reg;
        end
    end

    // ------------------------------------------------------------------
    // Outputs and vector fetch
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            halt_taken_o <= 1'b0;
            irq_taken_o  <= 1'b0;
            vec_rd_o     <= 1'b0;
            vec_addr_o   <= SCB_BASE;
            ipl_o        <= IPL_RESET;
            pc_o         <= GREG_RESET;
            sp_o         <= GREG_RESET;
        end else begin
            halt_taken_o <= halt_go;
            irq_taken_o  <= irq_go;
            if (irq_go) begin
                vec_rd_o   <= 1'b1;
                vec_addr_o <= SCB_BASE + irq_req_i.offset;
            end else if (vec_valid_i) begin
                vec_rd_o   <= 1'b0;
            end
            ipl_o <= cur_ipl;
            pc_o  <= greg_reg[GREG_PC_IDX];
            sp_o  <= greg_reg[GREG_SP_IDX];
        end
    end

    // ------------------------------------------------------------------
    // Cache internal processor registers
    // ------------------------------------------------------------------
    // Deallocate pulse.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bc_dealloc_o <= 1'b0;
            bc_blk_o     <= '0;
        end else begin
            bc_dealloc_o <= ipr_wr_i.bc_dealloc;
            if (ipr_wr_i.bc_dealloc) begin
                bc_blk_o <= ipr_wr_i.bc_blk;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < PC_PAR_N; i++) begin
                par_reg[i] <= '0;
            end
            par_rd_data_o <= '0;
        end else begin
            if (ipr_wr_i.par_we) begin
                par_reg[ipr_wr_i.par_idx] <= ipr_wr_i.par_data;
            end
            par_rd_data_o <= par_reg[par_rd_idx_i];
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_halt_seen;
        halt_go;
    endsequence

    AST_HALT_IPL: assert property (@(posedge clk_i) disable iff (rst_i)
        s_halt_seen |=> ipl_o == IPL_HALT || psl_reg[PSL_IPL_LSB +: IPL_W] == IPL_HALT)
        else $error("halt did not raise level");
    AST_HALT_CODE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_halt_seen |=> halt_save_o.code == HCODE_EXT_HALT)
        else $error("halt code wrong");
    AST_HALT_SAVE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_halt_seen |=> halt_save_o.pc == $past(greg_reg[GREG_PC_IDX]))
        else $error("halt pc not saved");
    AST_HALT_FW: assert property (@(posedge clk_i) disable iff (rst_i)
        s_halt_seen |=> ##1 pc_o == FW_ENTRY)
        else $error("no firmware jump");
    AST_HALT_ANY_IPL: assert property (@(posedge clk_i) disable iff (rst_i)
        halt_sync && state_reg == IHD_RUN |-> halt_go)
        else $error("halt blocked");
    AST_IRQ_IPL: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_go |=> cur_ipl == $past(irq_req_i.level))
        else $error("irq level not set");
    AST_IRQ_SAVE: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_go |=> saved_psl_o == $past(psl_reg))
        else $error("irq psl not saved");
    AST_IRQ_MASK: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_go |-> irq_req_i.level > cur_ipl)
        else $error("irq taken at or below level");
    AST_VEC_BRANCH: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == IHD_VFETCH && vec_valid_i |=> ##1 pc_o == $past(vec_data_i, 2))
        else $error("vector branch missing");
endmodule : ihd_dispatch
`default_nettype wire

/* tb/ihd_vec_model.sv */
// Vector table responder standing in for memory behind the control block.
`timescale 1ns/100ps
`default_nettype none
module ihd_vec_model
    import ihd_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              vec_rd_i,
    input  wire logic [DATA_W-1:0] vec_addr_i,
    input  wire logic [3:0]        dly_i,
    output var  logic              vec_valid_o,
    output var  logic [DATA_W-1:0] vec_data_o
);
    logic [3:0] cnt_reg  = 4'h0;
    logic       busy_reg = 1'b0;
    initial vec_valid_o = 1'b0;
    initial vec_data_o = 32'h0000_0000;
    // The data lines flip after each answer so a late sample never sees a stale vector.
    always @(negedge clk_i) begin
        vec_valid_o <= 1'b0;
        if (vec_valid_o) begin
            vec_data_o <= ~vec_data_o;
        end
        if (rst_i) begin
            busy_reg <= 1'b0;
        end else if (vec_rd_i && !busy_reg && !vec_valid_o) begin
            busy_reg <= 1'b1;
            cnt_reg  <= dly_i;
        end else if (busy_reg && cnt_reg == 4'h0) begin
            busy_reg    <= 1'b0;
            vec_valid_o <= 1'b1;
            vec_data_o  <= {vec_addr_i[15:0], 16'h8000};
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end
endmodule : ihd_vec_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking testbench for the interrupt and halt dispatch unit.
`timescale 1ns/100ps
`default_nettype none
module testbench
    import ihd_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, halt_req_i = 1'b0, psl_we_i = 1'b0, memory_mapping_enable_i = 1'b0;
    logic vec_rd_o, halt_taken_o, irq_taken_o, bc_dealloc_o, vec_valid_i;
    logic [DATA_W-1:0] psl_wr_data_i = '0, vec_data_i, vec_addr_o, pc_o, sp_o;
    logic [DATA_W-1:0] saved_pc_o, saved_psl_o, exp_pc, exp_sp, processor_status_longword, off, d;
    logic [IPL_W-1:0] ipl_o, cur, lvl;
    logic [BC_BLK_W-1:0] bc_blk_o;
    logic [PC_PAR_W-1:0] par_rd_data_o;
    logic [PC_PAR_IDX_W-1:0] par_rd_idx_i = '0;
    logic [3:0] dly = 4'h0;
    ihd_irq_req_s irq_req_i = '0;
    ihd_greg_wr_s greg_wr_i = '0;
    ihd_ipr_wr_s ipr_wr_i = '0;
    ihd_halt_save_s halt_save_o;
    int errors = 0, num_checks = 0, rnd, seen;

    always #2.5 clk_i = ~clk_i;

    ihd_dispatch ihd_dispatch_i (.clk_i(clk_i), .rst_i(rst_i), .halt_req_i(halt_req_i),
        .irq_req_i(irq_req_i), .greg_wr_i(greg_wr_i), .psl_wr_data_i(psl_wr_data_i),
        .psl_we_i(psl_we_i), .memory_mapping_enable_i(memory_mapping_enable_i), .ipr_wr_i(ipr_wr_i),
        .par_rd_idx_i(par_rd_idx_i), .vec_valid_i(vec_valid_i), .vec_data_i(vec_data_i),
        .vec_rd_o(vec_rd_o), .vec_addr_o(vec_addr_o), .halt_save_o(halt_save_o),
        .halt_taken_o(halt_taken_o), .irq_taken_o(irq_taken_o), .ipl_o(ipl_o), .pc_o(pc_o),
        .sp_o(sp_o), .saved_pc_o(saved_pc_o), .saved_psl_o(saved_psl_o),
        .bc_dealloc_o(bc_dealloc_o), .bc_blk_o(bc_blk_o), .par_rd_data_o(par_rd_data_o));

    ihd_vec_model ihd_vec_model_i (.clk_i(clk_i), .rst_i(rst_i), .vec_rd_i(vec_rd_o),
        .vec_addr_i(vec_addr_o), .dly_i(dly), .vec_valid_o(vec_valid_i),
        .vec_data_o(vec_data_i));

    // -------------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------------
    task automatic final_report;
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                       input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // A bounded wait; running out of cycles ends the run as a mismatch.
    task automatic wait_hi(ref logic s);
        for (int n = 0; n < 60 && s !== 1'b1; n++) begin
            @(negedge clk_i);
        end
        if (s !== 1'b1) begin
            errors++;
            $display("wrong value at %0t: handshake never came", $time);
            final_report();
        end
    endtask : wait_hi

    task automatic pulse_psl(input logic [DATA_W-1:0] v);
        psl_wr_data_i = v;
        psl_we_i = 1'b1;
        @(negedge clk_i);
        psl_we_i = 1'b0;
        @(negedge clk_i);
    endtask : pulse_psl

    task automatic greg(input logic [GREG_IDX_W-1:0] idx, input logic [DATA_W-1:0] v);
        greg_wr_i = '{we: 1'b1, idx: idx, data: v};
        @(negedge clk_i);
        greg_wr_i.we = 1'b0;
        @(negedge clk_i);
    endtask : greg

    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        final_report();
    end

    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial begin
        rnd = $urandom(32'he38f);
        memory_mapping_enable_i = 1'($urandom);
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        @(negedge clk_i);
        chk(DATA_W'(ipl_o), DATA_W'(IPL_RESET), "reset level");
        exp_pc = GREG_RESET;
        exp_sp = GREG_RESET;
        for (int i = 0; i < 16; i++) begin
            d = $urandom;
            greg(GREG_IDX_W'(i), d);
            if (i == 15) exp_pc = d;
            if (i == 14) exp_sp = d;
            chk(pc_o, exp_pc, "program counter");
            chk(sp_o, exp_sp, "stack top");
        end
        // Corner cases first: equal level refused, one above taken, then random.
        for (int i = 0; i < 10; i++) begin
            cur = IPL_W'($urandom_range(1, 20));
            lvl = (i == 0) ? cur : (i == 1) ? cur + 5'h1 : IPL_W'($urandom);
            processor_status_longword = $urandom;
            processor_status_longword[PSL_IPL_LSB +: IPL_W] = cur;
            pulse_psl(processor_status_longword);
            exp_pc = $urandom;
            greg(GREG_PC_IDX, exp_pc);
            off = $urandom & 32'h0000_0ffc;
            dly = 4'($urandom_range(0, 5));
            irq_req_i = '{valid: 1'b1, level: lvl, offset: off};
            if (lvl > cur) begin
                wait_hi(irq_taken_o);
                irq_req_i.valid = 1'b0;
                chk(saved_pc_o, exp_pc, "saved pc");
                chk(saved_psl_o, processor_status_longword, "saved status");
                chk(vec_addr_o, SCB_BASE_DEF + off, "vector address");
                for (int n = 0; n < 30 && vec_rd_o === 1'b1; n++) @(negedge clk_i);
                repeat (2) @(negedge clk_i);
                exp_pc = {SCB_BASE_DEF[15:0] + off[15:0], 16'h8000};
                chk(pc_o, exp_pc, "vectored pc");
                // The level output trails the status longword by one cycle.
                chk(DATA_W'(ipl_o), DATA_W'(lvl), "raised level");
            end else begin
                seen = 0;
                repeat (8) begin
                    @(negedge clk_i);
                    if (irq_taken_o !== 1'b0) seen = 1;
                end
                irq_req_i.valid = 1'b0;
                chk(DATA_W'(seen), 32'h0000_0000, "low irq taken");
                chk(DATA_W'(ipl_o), DATA_W'(cur), "level kept");
            end
            @(negedge clk_i);
        end
        // Halt taken at the highest level already in force.
        processor_status_longword = $urandom;
        processor_status_longword[PSL_IPL_LSB +: IPL_W] = IPL_HALT;
        pulse_psl(processor_status_longword);
        halt_req_i = 1'b1;
        wait_hi(halt_taken_o);
        chk(halt_save_o.pc, exp_pc, "halt pc");
        chk(halt_save_o.processor_status_longword, processor_status_longword, "halt status");
        chk(DATA_W'(halt_save_o.memory_mapping_enable), DATA_W'(memory_mapping_enable_i), "halt mapping");
        chk(DATA_W'(halt_save_o.code), DATA_W'(HCODE_EXT_HALT), "halt code");
        repeat (3) @(negedge clk_i);
        chk(pc_o, FW_ENTRY_DEF, "firmware entry");
        chk(DATA_W'(ipl_o), 32'h0000_001f, "halt level");
        halt_req_i = 1'b0;
        repeat (3) @(negedge clk_i);
        pulse_psl(32'h0002_0000);
        // Cache register groups.
        for (int i = 0; i < 8; i++) begin
            d = $urandom;
            ipr_wr_i = '{bc_dealloc: 1'b1, bc_blk: d[7:0], par_we: 1'b1,
                         par_idx: d[11:8], par_data: d[19:12]};
            @(negedge clk_i);
            ipr_wr_i = '0;
            par_rd_idx_i = d[11:8];
            chk(DATA_W'(bc_dealloc_o), 32'h0000_0001, "dealloc pulse");
            chk(DATA_W'(bc_blk_o), DATA_W'(d[7:0]), "dealloc block");
            repeat (2) @(negedge clk_i);
            chk(DATA_W'(bc_dealloc_o), 32'h0000_0000, "dealloc end");
            chk(DATA_W'(par_rd_data_o), DATA_W'(d[19:12]), "parity read");
        end
        final_report();
    end
endmodule : testbench
`default_nettype wire
